//--- inc/parport_pkg.sv
// Constants, types and decode helpers shared by the parallel port files
package parport_pkg;

    // ========================================================================
    // Timing
    localparam int CLK_MHZ    = 200;
    localparam int STROBE_NS  = 1500;
    localparam int SETUP_NS   = 1800;
    // Least times, rounded up to whole clock cycles
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;

    // ========================================================================
    // Port addresses and fields
    localparam logic [7:0] ADDR_CMD_STATUS  = 8'h88;
    localparam logic [7:0] ADDR_DATA_LOAD   = 8'h89;
    localparam logic [7:0] ADDR_STROBE      = 8'h8a;
    localparam logic [7:0] ADDR_LOAD_STROBE = 8'h8b;
    localparam int         CMD_INIT_BIT     = 7;
    localparam int         CMD_WAIT_BIT     = 6;
    localparam int         CMD_LOAD_BIT     = 0;
    localparam int         CMD_STROBE_BIT   = 1;
    localparam int         QCMD_W           = 2;
    localparam int         QWORD_W          = 10;

    // ========================================================================
    // Reset values
    localparam logic       RST_PRIME_N = 1'b0;
    localparam logic       RST_WAIT_EN = 1'b0;
    localparam logic       RST_STROBE_N = 1'b1;
    localparam logic [7:0] RST_PDATA   = 8'h00;
    localparam logic [7:0] UNDEF_READ  = 8'hff;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_PULSE
    } strobe_state_e;

    // ========================================================================
    // Decoding
    function automatic logic is_queue_addr(input logic [7:0] addr);
        return (addr == ADDR_DATA_LOAD) || (addr == ADDR_STROBE) ||
               (addr == ADDR_LOAD_STROBE);
    endfunction : is_queue_addr

    function automatic logic is_strobe_addr(input logic [7:0] addr);
        return (addr == ADDR_STROBE) || (addr == ADDR_LOAD_STROBE);
    endfunction : is_strobe_addr

endpackage : parport_pkg

//--- hdl/parport_buf.sv
// Two-entry buffer with valid/ready on both sides, read data muxed straight from the storage registers
`timescale 1ns/1ps
`default_nettype none
module parport_buf #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out,
    // Fill level
    output logic      [CNT_W-1:0] count_out
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic             push, pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction : ptr_inc

    always_comb begin
        push       = in_valid_in && (count_r != CNT_W'(DEPTH));
        pop        = out_ready_in && (count_r != '0);
        wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
        rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
        count_nxt  = count_r + CNT_W'(push) - CNT_W'(pop);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (ce_in) begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_in;
            end
        end
    end

    assign in_ready_out  = (count_r != CNT_W'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = mem_r[rd_ptr_r];
    assign count_out     = count_r;

endmodule : parport_buf
`default_nettype wire

//--- hdl/parport_top.sv
// Parallel output port with handshake, status read and command port
`timescale 1ns/1ps
`default_nettype none
module parport_top
    import parport_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int SETUP_CYCLES  = SETUP_CYC,
    parameter int BUF_DEPTH     = 2
) (
    // Clock, reset, enable
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    // Host I/O port
    input  wire logic [7:0] io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    output logic      [7:0] io_rdata_out,
    output logic            io_ready_out,
    // Board mode selection: 0 printer, 1 data
    input  wire logic       data_mode_in,
    // Far-end lines
    input  wire logic       ack_n_in,
    input  wire logic       demand_in,
    input  wire logic       power_on_in,
    input  wire logic       paper_motion_in,
    input  wire logic       fault_in,
    input  wire logic       select_in,
    input  wire logic       paper_out_in,
    input  wire logic       busy_in,
    input  wire logic       opt_data7_in,
    // Far-end outputs
    output logic      [7:0] pdata_out,
    output logic            strobe_n_out,
    output logic            prime_n_out,
    // Interrupt request toward the interrupt controller
    output logic            parallel_ack_irq_out
);
    localparam int TMR_W = $clog2(SETUP_CYCLES > STROBE_CYCLES ?
                                  SETUP_CYCLES : STROBE_CYCLES);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    // ========================================================================
    // Host side: command port, read data, ready
    logic [7:0]       rdata_r, rdata_nxt;
    logic             ready_r, ready_nxt;
    logic             prime_n_r, prime_n_nxt;
    logic             wait_en_r, wait_en_nxt;
    logic             ack_r, ack_nxt;
    logic [6:0]       lines;
    logic             hold, take, push, pend;
    logic             buf_in_ready, buf_out_valid, pop;
    logic [QWORD_W-1:0] buf_data;
    logic [CNT_W-1:0] buf_count, cnt_after;
    strobe_state_e    state_r, state_nxt;

    always_comb begin
        lines = {demand_in, power_on_in, paper_motion_in, fault_in,
                 select_in, paper_out_in, busy_in};
        // A strobe still queued or running has not been acknowledged yet
        pend  = (buf_count != '0) || (state_r != ST_IDLE);
        hold  = wait_en_r && is_strobe_addr(io_addr_in) && (!ack_r || pend);
        take  = io_wr_in && ready_r && !hold;
        push  = take && is_queue_addr(io_addr_in) && buf_in_ready;
        cnt_after = buf_count + CNT_W'(push) - CNT_W'(pop);
        // Not-ready while the buffer is full or a strobe write is held
        ready_nxt = (cnt_after != CNT_W'(BUF_DEPTH)) && !(io_wr_in && hold);

        prime_n_nxt = prime_n_r;
        wait_en_nxt = wait_en_r;
        if (take && (io_addr_in == ADDR_CMD_STATUS)) begin
            // Only the two top bits are sampled; the rest are dropped
            prime_n_nxt = !io_wdata_in[CMD_INIT_BIT];
            wait_en_nxt = io_wdata_in[CMD_WAIT_BIT];
        end

        rdata_nxt = rdata_r;
        if (io_rd_in) begin
            if (io_addr_in != ADDR_CMD_STATUS) begin
                rdata_nxt = UNDEF_READ;
            end else if (data_mode_in) begin
                rdata_nxt = {opt_data7_in, lines};
            end else begin
                rdata_nxt = {ack_r, lines};
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rdata_r   <= UNDEF_READ;
            ready_r   <= 1'b1;
            prime_n_r <= RST_PRIME_N;
            wait_en_r <= RST_WAIT_EN;
        end else if (ce_in) begin
            rdata_r   <= rdata_nxt;
            ready_r   <= ready_nxt;
            prime_n_r <= prime_n_nxt;
            wait_en_r <= wait_en_nxt;
        end
    end

    // ========================================================================
    // Command queue between host writes and the strobe engine
    parport_buf #(
        .WIDTH (QWORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (push),
        .in_ready_out  (buf_in_ready),
        .in_data_in    ({io_addr_in[1:0], io_wdata_in}),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (pop),
        .out_data_out  (buf_data),
        .count_out     (buf_count)
    );

    // ========================================================================
    // Strobe engine and acknowledge flag
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [7:0]       pdata_r, pdata_nxt;
    logic             strobe_n_r, strobe_n_nxt;
    logic             stb_start;
    logic [QCMD_W-1:0] qcmd;

    always_comb begin
        qcmd         = buf_data[QWORD_W-1:8];
        // Commands are taken only when idle, so a load never lands mid-pulse
        pop          = buf_out_valid && (state_r == ST_IDLE);
        state_nxt    = state_r;
        tmr_nxt      = tmr_r + TMR_W'(1);
        pdata_nxt    = pdata_r;
        strobe_n_nxt = strobe_n_r;
        stb_start    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                tmr_nxt = '0;
                if (pop && qcmd[CMD_LOAD_BIT]) begin
                    pdata_nxt = buf_data[7:0];
                end
                if (pop && qcmd[CMD_STROBE_BIT]) begin
                    if (qcmd[CMD_LOAD_BIT]) begin
                        state_nxt = ST_SETUP;
                    end else begin
                        state_nxt    = ST_PULSE;
                        strobe_n_nxt = 1'b0;
                        stb_start    = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                if (tmr_r == TMR_W'(SETUP_CYCLES - 1)) begin
                    state_nxt    = ST_PULSE;
                    tmr_nxt      = '0;
                    strobe_n_nxt = 1'b0;
                    stb_start    = 1'b1;
                end
            end
            ST_PULSE: begin
                if (tmr_r == TMR_W'(STROBE_CYCLES - 1)) begin
                    state_nxt    = ST_IDLE;
                    tmr_nxt      = '0;
                    strobe_n_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt    = ST_IDLE;
                tmr_nxt      = '0;
                strobe_n_nxt = 1'b1;
            end
        endcase
        // Set wins over the clear when both land in one cycle
        ack_nxt = ack_r;
        if (stb_start) begin
            ack_nxt = 1'b0;
        end
        if (!ack_n_in) begin
            ack_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r    <= ST_IDLE;
            tmr_r      <= '0;
            pdata_r    <= RST_PDATA;
            strobe_n_r <= RST_STROBE_N;
            ack_r      <= 1'b0;
        end else if (ce_in) begin
            state_r    <= state_nxt;
            tmr_r      <= tmr_nxt;
            pdata_r    <= pdata_nxt;
            strobe_n_r <= strobe_n_nxt;
            ack_r      <= ack_nxt;
        end
    end

    assign io_rdata_out         = rdata_r;
    assign io_ready_out         = ready_r;
    assign pdata_out            = pdata_r;
    assign strobe_n_out         = strobe_n_r;
    assign prime_n_out          = prime_n_r;
    assign parallel_ack_irq_out = ack_r;

    // ========================================================================
    // Assertions and their helper counters
    logic [9:0] lo_cnt_r;
    logic [9:0] since_load_r;
    logic       combo_r;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lo_cnt_r     <= '0;
            since_load_r <= '0;
            combo_r      <= 1'b0;
        end else if (ce_in) begin
            lo_cnt_r <= strobe_n_r ? 10'h000 : lo_cnt_r + 10'h001;
            // Every command rewrites the flag, so a bare strobe is never timed as a combined one
            if (pop) begin
                combo_r <= qcmd[CMD_LOAD_BIT] && qcmd[CMD_STROBE_BIT];
            end
            if (pop && qcmd[CMD_LOAD_BIT]) begin
                since_load_r <= '0;
            end else if (since_load_r != 10'h3ff) begin
                since_load_r <= since_load_r + 10'h001;
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence status_rd_s;
        ce_in && io_rd_in && (io_addr_in == ADDR_CMD_STATUS);
    endsequence
    sequence combo_pop_s;
        ce_in && pop && (qcmd == 2'h3);
    endsequence

    printer_status_a: assert property (status_rd_s and !data_mode_in |=>
        io_rdata_out == {$past(ack_r), $past(lines)})
        else $error("printer status read wrong");
    data_status_a: assert property (status_rd_s and data_mode_in |=>
        io_rdata_out == {$past(opt_data7_in), $past(lines)})
        else $error("data mode status read wrong");
    cmd_capture_a: assert property (ce_in && take &&
        io_addr_in == ADDR_CMD_STATUS |=> prime_n_out == !$past(io_wdata_in[7])
        && wait_en_r == $past(io_wdata_in[6]))
        else $error("command bits not captured");
    cmd_hold_a: assert property (!(take && io_addr_in == ADDR_CMD_STATUS)
        |=> $stable(prime_n_out) && $stable(wait_en_r))
        else $error("command bits changed without a write");
    reset_state_a: assert property (@(posedge core_clk_in) disable iff (1'b0)
        !rst_n_in |=> !prime_n_out && !wait_en_r && strobe_n_out)
        else $error("reset state wrong");
    undef_read_a: assert property (ce_in && io_rd_in &&
        is_queue_addr(io_addr_in) |=> io_rdata_out == UNDEF_READ)
        else $error("write-only port read value wrong");
    load_only_a: assert property (ce_in && pop && qcmd == 2'h1 |=>
        pdata_out == $past(buf_data[7:0]) && strobe_n_out && state_r == ST_IDLE)
        else $error("data load misbehaved");
    strobe_keep_a: assert property (ce_in && pop && qcmd == 2'h2 |=>
        !strobe_n_out && $stable(pdata_out))
        else $error("strobe changed output data");
    combo_load_a: assert property (combo_pop_s |=>
        pdata_out == $past(buf_data[7:0]) && state_r == ST_SETUP && strobe_n_out)
        else $error("load and strobe did not load first");
    strobe_width_a: assert property ($rose(strobe_n_out) |->
        lo_cnt_r == 10'(STROBE_CYCLES))
        else $error("strobe width wrong");
    setup_time_a: assert property ($fell(strobe_n_out) && combo_r |->
        since_load_r == 10'(SETUP_CYCLES))
        else $error("setup before strobe wrong");
    ack_set_a: assert property (ce_in && !ack_n_in |=> parallel_ack_irq_out)
        else $error("acknowledge not flagged");
    ack_clear_a: assert property ($fell(strobe_n_out) && $past(ack_n_in) |->
        !parallel_ack_irq_out)
        else $error("strobe did not clear acknowledge");
    wait_hold_a: assert property (io_wr_in && wait_en_r && !ack_r &&
        is_strobe_addr(io_addr_in) |-> !push)
        else $error("strobe write taken without acknowledge");

endmodule : parport_top
`default_nettype wire

//--- verif/parport_printer_model.sv
// Far-end printer model: acknowledges a strobe unless a later one ends before its delay runs out, and reports what it received
`timescale 1ns/1ps
`default_nettype none
module parport_printer_model (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    // Lines from the port
    input  wire logic       strobe_n_in,
    input  wire logic [7:0] pdata_in,
    input  wire logic       slow_in,
    // Acknowledge and report
    output logic            ack_n_out,
    output logic            rx_valid_out,
    output logic      [7:0] rx_byte_out,
    output logic      [7:0] rx_width_out,
    output logic      [7:0] rx_setup_out
);
    logic       strobe_n_r;
    logic [7:0] last_r;
    logic [7:0] stab_r;
    logic [7:0] wcnt_r;
    logic [7:0] byte_r;
    int         ack_dly_r;

    // Acknowledge line is pulled up, so it idles high between acknowledges
    always @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            strobe_n_r   <= 1'b1;
            ack_n_out    <= 1'b1;
            ack_dly_r    <= 0;
            rx_valid_out <= 1'b0;
            last_r       <= 8'h00;
            stab_r       <= 8'h00;
        end else begin
            strobe_n_r   <= strobe_n_in;
            last_r       <= pdata_in;
            stab_r       <= (pdata_in != last_r) ? 8'h01 : stab_r + {7'h0, stab_r != 8'hff};
            rx_valid_out <= !strobe_n_r && strobe_n_in;
            ack_n_out    <= !(ack_dly_r == 1 || ack_dly_r == 2);
            ack_dly_r    <= (ack_dly_r > 0) ? ack_dly_r - 1 : 0;
            if (strobe_n_r && !strobe_n_in) begin
                byte_r       <= pdata_in;
                rx_setup_out <= stab_r;
                wcnt_r       <= 8'h01;
            end else if (!strobe_n_in) begin
                wcnt_r <= wcnt_r + 8'h01;
            end
            if (!strobe_n_r && strobe_n_in) begin
                rx_byte_out  <= byte_r;
                rx_width_out <= wcnt_r;
                ack_dly_r    <= slow_in ? 42 : 4;
            end
        end
    end
endmodule : parport_printer_model
`default_nettype wire

//--- verif/test_parport_top.sv
// Self-checking bench for the parallel port: host driver, reference model, scoreboard
`timescale 1ns/1ps
`default_nettype none
module test_parport_top;
    import parport_pkg::*;
    localparam int SC = 4;
    localparam int TS = 6;
    // ========
    // Signals and reference state
    logic        core_clk_in = 1'b0;
    logic        rst_n_in    = 1'b0;
    logic [7:0]  addr        = 8'h00;
    logic [7:0]  wdata       = 8'h00;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic        mode        = 1'b0;
    logic        d7          = 1'b0;
    logic        slow        = 1'b0;
    logic        ce          = 1'b1;
    logic [6:0]  lines       = 7'h00;
    logic [7:0]  rdata, pdata, rx_byte, rx_width, rx_setup, v;
    logic        ready, strobe_n, prime_n, irq, ack_n, rx_valid;
    logic        mdl_wait    = 1'b0;
    logic [7:0]  mdl_pdata   = 8'h00;
    logic        saw_full    = 1'b0;
    logic [31:0] seed        = 32'd21;
    logic [7:0]  exp_q[$];
    bit          kind_q[$];
    int          miscompares = 0;
    int          n_compared  = 0;
    int          outstanding = 0;
    int          waited      = 0;

    parport_top #(.STROBE_CYCLES(SC), .SETUP_CYCLES(TS), .BUF_DEPTH(2)) i_dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .io_addr_in(addr),
        .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
        .io_ready_out(ready), .data_mode_in(mode), .ack_n_in(ack_n), .demand_in(lines[6]),
        .power_on_in(lines[5]), .paper_motion_in(lines[4]), .fault_in(lines[3]),
        .select_in(lines[2]), .paper_out_in(lines[1]), .busy_in(lines[0]),
        .opt_data7_in(d7), .pdata_out(pdata), .strobe_n_out(strobe_n),
        .prime_n_out(prime_n), .parallel_ack_irq_out(irq));

    parport_printer_model i_printer (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .strobe_n_in(strobe_n),
        .pdata_in(pdata), .slow_in(slow), .ack_n_out(ack_n), .rx_valid_out(rx_valid),
        .rx_byte_out(rx_byte), .rx_width_out(rx_width), .rx_setup_out(rx_setup));

    always #2.5 core_clk_in = ~core_clk_in;

    // ========
    // Helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp8

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge core_clk_in);
            wr = 1'b0;
        end
    endtask : idle

    // Holds the write until the port can take it; the hold model decides when that is
    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        logic held;
        waited = 0;
        @(negedge core_clk_in);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        held  = 1'b1;
        while (held && waited < 3000) begin
            held = (ready !== 1'b1) || (mdl_wait && (a == ADDR_STROBE || a == ADDR_LOAD_STROBE)
                   && (irq !== 1'b1 || outstanding > 0));
            if (held) begin
                waited++;
                @(negedge core_clk_in);
            end
        end
        if (held) miscompares++;
        @(posedge core_clk_in);
        if (a == ADDR_DATA_LOAD || a == ADDR_LOAD_STROBE) mdl_pdata = d;
        if (a == ADDR_STROBE || a == ADDR_LOAD_STROBE) begin
            exp_q.push_back(mdl_pdata);
            kind_q.push_back(a == ADDR_LOAD_STROBE);
            outstanding++;
        end
        if (a == ADDR_CMD_STATUS) mdl_wait = d[6];
    endtask : host_wr

    task automatic host_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_in);
        wr   = 1'b0;
        addr = a;
        rd   = 1'b1;
        @(negedge core_clk_in);
        rd = 1'b0;
        cmp8(exp, rdata);
    endtask : host_rd

    task automatic drain();
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) idle(1);
        idle(60);
    endtask : drain

    // ========
    // Scoreboard against the printer's view
    always @(posedge core_clk_in) begin
        if (wr && ready !== 1'b1) saw_full = 1'b1;
        if (rx_valid === 1'b1) begin
            cmp8(8'h01, {7'h0, exp_q.size() > 0});
            if (exp_q.size() > 0) begin
                cmp8(exp_q.pop_front(), rx_byte);
                if (kind_q.pop_front()) cmp8(8'h01, {7'h0, rx_setup >= 8'(TS)});
            end
            cmp8(8'(SC), rx_width);
            outstanding--;
        end
    end

    task automatic end_of_test();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares++;
        end_of_test();
    end

    // ========
    // Main sequence
    initial begin
        idle(16);
        rst_n_in = 1'b1;
        cmp8(8'h00, {7'h0, prime_n});
        cmp8(8'h01, {7'h0, strobe_n});
        cmp8(8'h00, pdata);
        cmp8(8'h00, {7'h0, irq});
        for (int i = 1; i < 4; i++) host_rd(ADDR_CMD_STATUS + 8'(i), UNDEF_READ);
        host_wr(ADDR_CMD_STATUS, 8'h3f);
        idle(2);
        cmp8(8'h01, {7'h0, prime_n});
        v = rnd();
        host_wr(ADDR_CMD_STATUS, {2'b10, v[5:0]});
        idle(2);
        cmp8(8'h00, {7'h0, prime_n});
        host_wr(ADDR_CMD_STATUS, 8'h3f);
        idle(2);
        cmp8(8'h01, {7'h0, prime_n});
        for (int i = 0; i < 8; i++) begin
            v     = rnd();
            lines = v[6:0];
            d7    = v[7];
            mode  = i[0];
            host_rd(ADDR_CMD_STATUS, mode ? v : {1'b0, v[6:0]});
        end
        // After status reads the read register no longer holds its reset value
        host_rd(ADDR_LOAD_STROBE, UNDEF_READ);
        mode = 1'b0;
        v    = rnd();
        host_wr(ADDR_DATA_LOAD, v);
        host_wr(8'h87, 8'hff);
        idle(TS + SC + 4);
        cmp8(mdl_pdata, pdata);
        cmp8(8'h01, {7'h0, prime_n});
        // Printer stalls its acknowledge; with wait off, queued strobes alone fill the two-entry buffer so it must refuse
        slow     = 1'b1;
        saw_full = 1'b0;
        for (int i = 0; i < 9; i++) begin
            v = rnd();
            host_wr((i < 3) ? ADDR_LOAD_STROBE : ADDR_DATA_LOAD + 8'(i % 3), v);
        end
        drain();
        cmp8(8'h01, {7'h0, saw_full});
        cmp8(mdl_pdata, pdata);
        cmp8(8'h01, {7'h0, irq});
        host_rd(ADDR_CMD_STATUS, {1'b1, lines});
        // Clock enable low must freeze the read data register
        ce = 1'b0;
        host_rd(ADDR_STROBE, {1'b1, lines});
        ce = 1'b1;
        host_wr(ADDR_STROBE, 8'h00);
        idle(2);
        cmp8(8'h00, {7'h0, irq});
        cmp8(8'h00, {7'h0, strobe_n});
        host_wr(ADDR_CMD_STATUS, 8'h40);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            host_wr(ADDR_LOAD_STROBE, v);
            cmp8(8'h01, {7'h0, waited > 30});
        end
        drain();
        cmp8(8'h01, {7'h0, prime_n});
        rst_n_in = 1'b0;
        idle(2);
        rst_n_in    = 1'b1;
        mdl_wait    = 1'b0;
        mdl_pdata   = 8'h00;
        outstanding = 0;
        cmp8(8'h00, {7'h0, prime_n});
        cmp8(8'h00, {7'h0, irq});
        host_wr(ADDR_CMD_STATUS, 8'h00);
        idle(2);
        cmp8(8'h01, {7'h0, prime_n});
        end_of_test();
    end
endmodule : test_parport_top
`default_nettype wire
